/* File: pkg/sanp_pkg.sv */
// package: register map, field layout and reset values of the partner ability register bank
`default_nettype none
package sanp_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   // register addresses as printed (not all multiples of four: plain port, printed offsets)
   localparam logic [23:0] ADDR_PARTNER_ABILITY = 24'h1F0005;
   localparam logic [23:0] ADDR_AUTONEG_EXPANSION = 24'h1F0006;
   localparam logic [23:0] ADDR_DIGITAL_CTRL = 24'h1F8000;
   localparam logic [23:0] ADDR_PCS_CTRL = 24'h1F8001;
   localparam logic [23:0] ADDR_AN_STATUS = 24'h1F0001;
   localparam logic [23:0] ADDR_IRQ_STATUS = 24'h1F8010;
   localparam logic [23:0] ADDR_IRQ_MASK = 24'h1F8011;
   // partner ability fields
   localparam int PA_NEXT_PAGE = 15;
   localparam int PA_ACK = 14;
   localparam int PA_FAULT_HI = 13;
   localparam int PA_FAULT_LO = 12;
   localparam int PA_PAUSE_HI = 8;
   localparam int PA_PAUSE_LO = 7;
   localparam int PA_HALF_DUPLEX = 6;
   localparam int PA_FULL_DUPLEX = 5;
   localparam logic [15:0] PA_USED_MASK = 16'hF1E0;
   // expansion
   localparam int EXP_PAGE_RX = 1;
   // digital control
   localparam int DC_REMOTE_LOOP = 14;
   localparam int DC_POWER_SAVE = 11;
   localparam logic [15:0] DC_RESET = 16'h2400;
   // pcs control
   localparam int PC_MODE_HI = 2;
   localparam int PC_MODE_LO = 1;
   localparam logic [1:0] MODE_SERDES = 2'h0;
   localparam logic [1:0] MODE_SGMII = 2'h2;
   localparam logic [15:0] PC_RESET = 16'h0004;
   localparam logic [15:0] PC_WMASK = 16'h001F;
   // status register
   localparam int ST_AN_DONE = 5;
   localparam logic [15:0] ST_FIXED = 16'h0189;
   // interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_AN_DONE = 0;
   localparam int IRQ_PAGE_RX = 1;
   localparam int IRQ_ACK_RX = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
endpackage
`default_nettype wire

/* File: rtl/sanp_regs.sv */
// partner ability, expansion and digital control registers of the serial gigabit pcs port
//
// Added by the designer: strobed register access.
`default_nettype none
module sanp_regs
   import sanp_pkg::*;
#(
   parameter int SER_W = 10
) (
   input wire logic clock, // 100 mhz core clock
   input wire logic rst, // async reset, active high
   input wire logic [ADDR_W-1:0] reg_addr, // register address
   input wire logic [DATA_W-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
   input wire logic an_page_rx, // pulse: codeword page received
   input wire logic [DATA_W-1:0] an_page_word, // codeword beside an_page_rx
   input wire logic an_complete, // pulse: acknowledge codewords exchanged
   input wire logic an_restart, // pulse: negotiation restarted, partner data stale
   input wire logic [SER_W-1:0] pcs_rx_data, // decoded receive data
   input wire logic [SER_W-1:0] pcs_tx_data, // local transmit data
   output logic [SER_W-1:0] ser_tx_data, // data to serializer
   output logic ser_rx_en, // receiver enable
   output logic ser_tx_en, // transmitter enable
   output logic ser_pll_en, // pll enable
   output logic next_page_en, // local next-page request, never set
   output logic irq // level interrupt
);
   logic [DATA_W-1:0] partner_ff;
   logic [DATA_W-1:0] pending_word_ff;
   // negotiation phase; partner data is trusted only in the done phase
   typedef enum logic [1:0] {
      SANP_IDLE,
      SANP_PAGE,
      SANP_DONE
   } sanp_phase_t;

   sanp_phase_t phase_ff;
   sanp_phase_t nxt_phase;
   logic an_done;
   logic [SER_W-1:0] nxt_tx;
   logic [DATA_W-1:0] nxt_partner;
   logic [DATA_W-1:0] commit_word;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] expansion_word;
   logic [IRQ_W-1:0] irq_clear;
   logic power_save;
   logic remote_loop;
   logic wr_dig_ctrl;
   logic wr_pcs_ctrl;
   logic wr_irq_status;
   logic wr_irq_mask;

   // partner fields, named so the rebuilt word below is readable
   logic pa_next_page;
   logic pa_ack;
   logic [1:0] pa_fault;
   logic [1:0] pa_pause;
   logic pa_half;
   logic pa_full;

   logic page_rx_ff;
   logic [DATA_W-1:0] dig_ctrl_ff;
   logic [DATA_W-1:0] pcs_ctrl_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [SER_W-1:0] tx_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic [DATA_W-1:0] partner_view;
   logic [IRQ_W-1:0] irq_event;
   logic serdes_mode;
   logic exp_read;

   // register strobe decode; every strobe is one cycle, so each hit acts once
   assign exp_read = reg_rd && reg_addr == ADDR_AUTONEG_EXPANSION;
   assign wr_dig_ctrl = reg_wr && reg_addr == ADDR_DIGITAL_CTRL;
   assign wr_pcs_ctrl = reg_wr && reg_addr == ADDR_PCS_CTRL;
   assign wr_irq_status = reg_wr && reg_addr == ADDR_IRQ_STATUS;
   assign wr_irq_mask = reg_wr && reg_addr == ADDR_IRQ_MASK;

   // reserved mode codes count as not 1000BASE-X, so partner fields stay hidden
   assign serdes_mode = pcs_ctrl_ff[PC_MODE_HI:PC_MODE_LO] == MODE_SERDES;
   assign power_save = dig_ctrl_ff[DC_POWER_SAVE];
   assign remote_loop = dig_ctrl_ff[DC_REMOTE_LOOP];

   // newest page kept until completion commits it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pending_word_ff <= '0;
      end else if (an_page_rx) begin
         pending_word_ff <= an_page_word;
      end
   end

   // a page in the completing cycle is newer than the held one
   assign commit_word = an_page_rx ? an_page_word : pending_word_ff;

   assign pa_next_page = commit_word[PA_NEXT_PAGE];
   assign pa_ack = commit_word[PA_ACK];
   assign pa_fault = commit_word[PA_FAULT_HI:PA_FAULT_LO];
   assign pa_pause = commit_word[PA_PAUSE_HI:PA_PAUSE_LO];
   assign pa_half = commit_word[PA_HALF_DUPLEX];
   assign pa_full = commit_word[PA_FULL_DUPLEX];

   // reserved bits are rebuilt as zero rather than copied from the line
   always_comb begin
      nxt_partner = '0;
      nxt_partner[PA_NEXT_PAGE] = pa_next_page;
      nxt_partner[PA_ACK] = pa_ack;
      nxt_partner[PA_FAULT_HI:PA_FAULT_LO] = pa_fault;
      nxt_partner[PA_PAUSE_HI:PA_PAUSE_LO] = pa_pause;
      nxt_partner[PA_HALF_DUPLEX] = pa_half;
      nxt_partner[PA_FULL_DUPLEX] = pa_full;
   end

   // partner ability: committed at completion, cleared by restart
   // completion wins over a restart, so a late restart cannot erase fresh data
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         partner_ff <= '0;
      end else if (an_complete) begin
         partner_ff <= nxt_partner;
      end else if (an_restart) begin
         partner_ff <= '0;
      end
   end

   // fields have meaning only in 1000BASE-X mode
   assign partner_view = serdes_mode ? partner_ff : '0;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase_ff <= SANP_IDLE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // completion wins over a restart in the same cycle
   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         SANP_IDLE: begin
            if (an_complete) begin
               nxt_phase = SANP_DONE;
            end else if (an_page_rx) begin
               nxt_phase = SANP_PAGE;
            end
         end
         SANP_PAGE: begin
            if (an_complete) begin
               nxt_phase = SANP_DONE;
            end else if (an_restart) begin
               nxt_phase = SANP_IDLE;
            end
         end
         SANP_DONE: begin
            // a repeated completion keeps the phase; only a restart leaves it
            if (an_restart && !an_complete) begin
               nxt_phase = SANP_IDLE;
            end
         end
         default: nxt_phase = SANP_IDLE;
      endcase
   end

   // partner data is valid once acknowledge codewords were exchanged
   assign an_done = phase_ff == SANP_DONE;

   // latched high; a page arriving in the reading cycle wins over the clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         page_rx_ff <= 1'b0;
      end else if (an_page_rx) begin
         page_rx_ff <= 1'b1;
      end else if (exp_read) begin
         page_rx_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dig_ctrl_ff <= DC_RESET;
      end else if (wr_dig_ctrl) begin
         // reserved bits stay writable; software preserves them
         dig_ctrl_ff <= reg_wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pcs_ctrl_ff <= PC_RESET;
      end else if (wr_pcs_ctrl) begin
         pcs_ctrl_ff <= reg_wdata & PC_WMASK;
      end
   end

   // interrupts: sticky, write one to clear, set wins
   always_comb begin
      irq_event[IRQ_AN_DONE] = an_complete;
      irq_event[IRQ_PAGE_RX] = an_page_rx;
      irq_event[IRQ_ACK_RX] = an_complete && pa_ack;
   end

   // clear bits apply only on a write to the status address
   assign irq_clear = wr_irq_status ? reg_wdata[IRQ_W-1:0] : '0;

   generate
      for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               irq_stat_ff[i] <= IRQ_RESET[i];
            end else if (irq_event[i]) begin
               irq_stat_ff[i] <= 1'b1;
            end else if (irq_clear[i]) begin
               irq_stat_ff[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_mask_ff <= IRQ_RESET;
      end else if (wr_irq_mask) begin
         irq_mask_ff <= reg_wdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

   // status word: fixed bits plus the completion flag
   always_comb begin
      status_word = ST_FIXED;
      status_word[ST_AN_DONE] = an_done;
   end

   always_comb begin
      expansion_word = '0;
      expansion_word[EXP_PAGE_RX] = page_rx_ff;
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      nxt_rdata = '0;
      case (reg_addr)
         ADDR_PARTNER_ABILITY: begin
            nxt_rdata = partner_view;
         end
         ADDR_AUTONEG_EXPANSION: begin
            nxt_rdata = expansion_word;
         end
         ADDR_DIGITAL_CTRL: begin
            nxt_rdata = dig_ctrl_ff;
         end
         ADDR_PCS_CTRL: begin
            nxt_rdata = pcs_ctrl_ff;
         end
         ADDR_AN_STATUS: begin
            nxt_rdata = status_word;
         end
         ADDR_IRQ_STATUS: begin
            nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
         end
         ADDR_IRQ_MASK: begin
            nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
         end
         default: nxt_rdata = '0;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_ff <= '0;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= '0;
      end
   end
   assign reg_rdata = rdata_ff;

   // remote loopback sends receive data back out on the line; power save blanks the line
   // power save is checked first so a looped port also goes quiet
   always_comb begin
      if (power_save) begin
         nxt_tx = '0;
      end else if (remote_loop) begin
         nxt_tx = pcs_rx_data;
      end else begin
         nxt_tx = pcs_tx_data;
      end
   end

   // one register stage keeps the serializer input glitch free
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_ff <= '0;
      end else begin
         tx_ff <= nxt_tx;
      end
   end
   assign ser_tx_data = tx_ff;

   // the pll is left running in power save so the wake-up needs no relock
   assign ser_rx_en = !power_save;
   assign ser_tx_en = !power_save;
   assign ser_pll_en = 1'b1;
   // local side has no next-page support, so no exchange starts
   assign next_page_en = 1'b0;
endmodule
`default_nettype wire

/* File: verif/sanp_partner.sv */
// link partner model: sends one base page, then completion after a chosen gap
`default_nettype none
module sanp_partner (
   input wire logic clock, // core clock
   input wire logic rst, // async reset, active high
   input wire logic go, // start one page exchange
   input wire logic [1:0] gap, // extra cycles before completion
   input wire logic [15:0] word, // base codeword to send
   output logic an_page_rx, // page strobe
   output logic [15:0] an_page_word, // page word, valid beside the strobe
   output logic an_complete, // completion strobe
   output logic [9:0] pcs_rx_data // receive pattern, new value every cycle
);
   logic [2:0] cnt_ff;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         an_page_rx <= 1'b0;
         an_page_word <= 16'h0000;
         an_complete <= 1'b0;
         cnt_ff <= 3'h0;
         pcs_rx_data <= 10'h000;
      end else begin
         an_page_rx <= go;
         // word is stale outside the strobe, so it is inverted there
         an_page_word <= go ? word : ~an_page_word;
         an_complete <= (cnt_ff == 3'h1);
         cnt_ff <= go ? {1'b0, gap} + 3'h1 : cnt_ff - {2'h0, cnt_ff != 3'h0};
         pcs_rx_data <= pcs_rx_data + 10'h001;
      end
   end
endmodule
`default_nettype wire

/* File: verif/sanp_regs_sva.sv */
// port assertions for the partner ability register bank
`default_nettype none
module sanp_regs_chk
   import sanp_pkg::*;
#(parameter int SER_W = 10) (
   input wire logic clock, // core clock
   input wire logic rst, // async reset
   input wire logic [ADDR_W-1:0] reg_addr, // address
   input wire logic reg_rd, // read strobe
   input wire logic [DATA_W-1:0] reg_rdata, // read data
   input wire logic an_page_rx, // page strobe
   input wire logic [SER_W-1:0] ser_tx_data, // serializer data
   input wire logic ser_rx_en, // receiver enable
   input wire logic ser_tx_en, // transmitter enable
   input wire logic ser_pll_en, // pll enable
   input wire logic next_page_en // next-page request
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence exp_rd;
      reg_rd && reg_addr == ADDR_AUTONEG_EXPANSION;
   endsequence
   no_next_page_a: assert property (next_page_en == 1'b0)
      else $error("next page request raised");
   pll_stays_on_a: assert property (ser_pll_en == 1'b1)
      else $error("pll enable dropped");
   rx_tx_pair_a: assert property (ser_rx_en == ser_tx_en)
      else $error("receiver and transmitter enables differ");
   save_mute_a: assert property (!ser_tx_en |=> ser_tx_data == '0)
      else $error("transmit data not quiet in power save");
   page_set_a: assert property (an_page_rx ##1 exp_rd |=> reg_rdata[EXP_PAGE_RX])
      else $error("page flag missing after page");
   page_clear_a: assert property ((exp_rd ##0 !an_page_rx) ##1 exp_rd
      |=> !reg_rdata[EXP_PAGE_RX]) else $error("page flag kept after read");
   pa_reserved_a: assert property ($past(reg_rd) &&
      $past(reg_addr) == ADDR_PARTNER_ABILITY |-> (reg_rdata & ~PA_USED_MASK) == 16'h0000)
      else $error("reserved partner bits not zero");
   // read data must stay zero off its cycle so a shared read mux sees no stale value
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
endmodule
bind sanp_regs sanp_regs_chk #(.SER_W(SER_W)) i_sanp_regs_chk (.clock, .rst, .reg_addr,
   .reg_rd, .reg_rdata, .an_page_rx, .ser_tx_data, .ser_rx_en, .ser_tx_en, .ser_pll_en,
   .next_page_en);
`default_nettype wire

/* File: verif/sanp_regs_tb_top.sv */
// self-checking bench for the partner ability register bank
`default_nettype none
module sanp_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sanp_pkg::*;
   logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, an_restart = 1'b0;
   logic irq, ser_rx_en, ser_tx_en, ser_pll_en, an_page_rx, an_complete, next_page_en;
   logic [1:0] gap = 2'h0;
   logic [ADDR_W-1:0] reg_addr = 24'h000000;
   logic [15:0] reg_wdata = 16'h0000, word = 16'h0000, reg_rdata, an_page_word, d, e;
   logic [9:0] pcs_tx_data = 10'h2AA, pcs_rx_data, ser_tx_data;
   int bad_count = 0, n_checks = 0;
   sanp_regs i_sanp_regs (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .an_page_rx, .an_page_word, .an_complete, .an_restart, .pcs_rx_data, .pcs_tx_data,
      .ser_tx_data, .ser_rx_en, .ser_tx_en, .ser_pll_en, .next_page_en, .irq);
   sanp_partner i_sanp_partner (.clock, .rst, .go, .gap, .word, .an_page_rx, .an_page_word,
      .an_complete, .pcs_rx_data);
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] ex, logic [15:0] got);
      n_checks++;
      if (got !== ex) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, ex, got);
      end
   endtask
   // tasks start just after an edge and end 1 ns after one, so calls run back to back
   task automatic wr(logic [23:0] a, logic [15:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [23:0] a);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rc(logic [23:0] a, logic [15:0] ex);
      rd(a);
      chk($sformatf("reg %h", a), ex, d);
   endtask
   task automatic xchg(logic [15:0] w, logic [1:0] g);
      go <= 1'b1;
      word <= w;
      gap <= g;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      #1;
      rc(ADDR_AUTONEG_EXPANSION, 16'h0002);
      rc(ADDR_AUTONEG_EXPANSION, 16'h0000);
      for (int i = 0; i < 8 && an_complete !== 1'b1; i++) @(negedge clock);
      if (an_complete !== 1'b1) begin
         bad_count++;
         wrap_up();
      end
      @(posedge clock);
      #1;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      rc(ADDR_DIGITAL_CTRL, DC_RESET);
      rc(ADDR_PARTNER_ABILITY, 16'h0000);
      rc(24'h1F0007, 16'h0000);
      wr(ADDR_PCS_CTRL, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         e = {i[1], i[0], i[1:0], 3'h0, i[1:0], i[0], i[1], 5'h00};
         xchg(e | 16'h0E1F, {1'b1, i[0]});
         rc(ADDR_PARTNER_ABILITY, e);
      end
      rc(ADDR_AN_STATUS, ST_FIXED | 16'h0020);
      wr(ADDR_PCS_CTRL, PC_RESET);
      rc(ADDR_PARTNER_ABILITY, 16'h0000);
      wr(ADDR_PCS_CTRL, 16'h0002);
      rc(ADDR_PARTNER_ABILITY, 16'h0000);
      wr(ADDR_PCS_CTRL, 16'h0000);
      rc(ADDR_PARTNER_ABILITY, e);
      chk("irq", 16'h0000, {15'h0000, irq});
      rc(ADDR_IRQ_STATUS, 16'h0007);
      wr(ADDR_IRQ_MASK, 16'h0001);
      chk("irq", 16'h0001, {15'h0000, irq});
      wr(ADDR_IRQ_STATUS, 16'h0007);
      chk("irq", 16'h0000, {15'h0000, irq});
      rc(ADDR_IRQ_STATUS, 16'h0000);
      an_restart <= 1'b1;
      @(posedge clock);
      an_restart <= 1'b0;
      #1;
      rc(ADDR_PARTNER_ABILITY, 16'h0000);
      rd(ADDR_DIGITAL_CTRL);
      wr(ADDR_DIGITAL_CTRL, d | 16'h4000);
      @(posedge clock);
      #1;
      chk("tx data", {6'h00, pcs_rx_data - 10'h001}, {6'h00, ser_tx_data});
      wr(ADDR_DIGITAL_CTRL, d | 16'h0800);
      chk("enables", 16'h0001, {13'h0000, ser_rx_en, ser_tx_en, ser_pll_en});
      @(posedge clock);
      #1;
      chk("tx data", 16'h0000, {6'h00, ser_tx_data});
      wr(ADDR_DIGITAL_CTRL, d);
      @(posedge clock);
      #1;
      chk("tx data", {6'h00, pcs_tx_data}, {6'h00, ser_tx_data});
      chk("enables", 16'h0007, {13'h0000, ser_rx_en, ser_tx_en, ser_pll_en});
      rc(ADDR_DIGITAL_CTRL, d);
      wrap_up();
   end
endmodule
`default_nettype wire
